// *** verilog/vme_cfg_pkg.sv ***
// Constants and types shared by the device configuration register bank
`default_nettype none

package vme_cfg_pkg;

   // ------------------------------------------------------------
   // Register map and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] DEV_CFG_OFFSET = 8'h40;
   localparam int         ARB_EN_BIT     = 31;
   localparam int         ARB_MODE_LSB   = 29;
   localparam int         ERR_SUM_BIT    = 28;
   localparam int         PAGE_LSB       = 26;
   localparam int         REQ_LSB        = 24;
   localparam int         WR_DIR_BIT     = 23;
   localparam int         SM_RESET_BIT   = 22;
   localparam int         ARB_TO_LSB     = 19;
   localparam int         XACT_TO_LSB    = 16;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic       ARB_EN_RST     = 1'h1;
   localparam logic [1:0] PAGE_RST       = 2'h0;
   localparam logic [1:0] REQ_RST        = 2'h3;
   localparam logic [1:0] REQ_LINE_THREE = 2'h3;
   localparam logic [2:0] ARB_TO_RST     = 3'h7;
   localparam logic [2:0] XACT_TO_RST    = 3'h7;
   localparam logic [2:0] TO_DISABLED    = 3'h7;
   localparam int         OTHER_ERR_W    = 5;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      round_robin_mode,
      fixed_priority_mode,
      prioritized_round_robin_mode,
      single_level_mode
   } arb_mode_t;

   typedef enum logic [1:0] {
      page_4k,
      page_8k,
      page_512,
      page_undefined
   } page_size_t;

   // ------------------------------------------------------------
   // Timing: times in ns, counts in 50 ns cycles
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_800NS_NS    = 800;
   localparam int T_12US8_NS    = 12800;
   localparam int T_32US_NS     = 32000;
   localparam int T_64US_NS     = 64000;
   localparam int T_128US_NS    = 128000;
   localparam int T_819US_NS    = 819000;
   localparam int T_3MS28_NS    = 3280000;
   localparam int CYC_800NS     = T_800NS_NS / CLK_PERIOD_NS;
   localparam int CYC_12US8     = T_12US8_NS / CLK_PERIOD_NS;
   localparam int CYC_32US      = T_32US_NS / CLK_PERIOD_NS;
   localparam int CYC_64US      = T_64US_NS / CLK_PERIOD_NS;
   localparam int CYC_128US     = T_128US_NS / CLK_PERIOD_NS;
   localparam int CYC_819US     = T_819US_NS / CLK_PERIOD_NS;
   localparam int CYC_3MS28     = T_3MS28_NS / CLK_PERIOD_NS;
   localparam int TMR_W         = 17;

endpackage

`default_nettype wire

// *** verilog/timeout_timer.sv ***
// Single timeout counter, reused for arbitration and transaction timing
`timescale 1ns/100ps
`default_nettype none

module timeout_timer
   import vme_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   // Control
   input  wire logic                     restart,
   input  wire logic                     active,
   input  wire logic                     disabled,
   input  wire logic [TMR_W-1:0]         limit,
   // Result
   output logic                          expire
);

   typedef enum logic [1:0] {tmr_idle, tmr_run, tmr_done} timer_state_t;

   timer_state_t     state;
   logic [TMR_W-1:0] count;

   // ------------------------------------------------------------
   // Counter: one expiry per wait, rearmed when the wait ends
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset || restart) begin
         state  <= tmr_idle;
         count  <= '0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         case (state)
            tmr_idle: begin
               count <= '0;
               if (active && !disabled) begin
                  state <= tmr_run;
               end
            end
            tmr_run: begin
               if (!active || disabled) begin
                  state <= tmr_idle;
               end else if (count == limit - TMR_W'(1)) begin
                  state  <= tmr_done;
                  expire <= 1'b1;
               end else begin
                  count <= count + TMR_W'(1);
               end
            end
            tmr_done: begin
               // Held here so one long stall reports once only
               if (!active) begin
                  state <= tmr_idle;
               end
            end
            default: state <= tmr_idle;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // disabled code never expires
   chk_disabled_silent: assert property (@(posedge ref_clk) disable iff (reset)
      disabled |=> !expire)
      else $error("timer expired while disabled");

endmodule // timeout_timer

`default_nettype wire

// *** verilog/error_summary.sv ***
// Timeout error flags, bus error mirror and the error summary bit
`timescale 1ns/100ps
`default_nettype none

module error_summary
   import vme_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   reset,
   // Events and levels
   input  wire logic                   arb_expire,
   input  wire logic                   xact_expire,
   input  wire logic [OTHER_ERR_W-1:0] other_errors,
   input  wire logic                   vme_berr_n,
   // Clears from the error register
   input  wire logic                   clr_arb_timeout,
   input  wire logic                   clr_xact_timeout,
   // Status
   output logic                        arb_timeout_flag,
   output logic                        xact_timeout_flag,
   output logic                        berr_status,
   output logic                        error_summary_bit
);

   logic next_arb_flag;
   logic next_xact_flag;
   logic next_berr;

   // Set beats clear so an expiry in the clear cycle is kept
   always_comb begin
      next_arb_flag  = arb_expire  || (arb_timeout_flag  && !clr_arb_timeout);
      next_xact_flag = xact_expire || (xact_timeout_flag && !clr_xact_timeout);
      next_berr      = !vme_berr_n;
   end

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   // timeout sets sticky flag
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         arb_timeout_flag  <= 1'b0;
         xact_timeout_flag <= 1'b0;
      end else begin
         arb_timeout_flag  <= next_arb_flag;
         xact_timeout_flag <= next_xact_flag;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         berr_status <= 1'b0;
      end else begin
         berr_status <= next_berr;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         error_summary_bit <= 1'b0;
      end else begin
         error_summary_bit <= (|other_errors) || next_arb_flag || next_xact_flag || next_berr;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_summary_or_all: assert property (@(posedge ref_clk) disable iff (reset)
      !$past(reset) |-> error_summary_bit == (arb_timeout_flag || xact_timeout_flag
                                              || berr_status || (|$past(other_errors))))
      else $error("error summary is not the OR of error bits");
   chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
      (arb_expire || xact_expire) |=> (arb_timeout_flag || xact_timeout_flag) && error_summary_bit)
      else $error("timeout did not raise flag and summary");
   chk_berr_mirror: assert property (@(posedge ref_clk) disable iff (reset)
      !$past(reset) && !$past(vme_berr_n) |-> berr_status ##0 error_summary_bit)
      else $error("bus error status does not follow the line");

endmodule // error_summary

`default_nettype wire

// *** verilog/vme_adapter_config_control.sv ***
// Device configuration register bank for the VME side of the adapter
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// ------------------------------------------------------------

module vme_adapter_config_control
   import vme_cfg_pkg::*;
#(
   parameter int CYC_819US_P = vme_cfg_pkg::CYC_819US,
   parameter int CYC_3MS28_P = vme_cfg_pkg::CYC_3MS28
)
(
   // Clock and reset
   input  wire logic                               ref_clk,
   input  wire logic                               reset,
   // Register port
   input  wire logic [7:0]                         cfg_addr,
   input  wire logic                               cfg_write,
   input  wire logic                               cfg_read,
   input  wire logic [31:0]                        cfg_wdata,
   output logic      [31:0]                        cfg_rdata,
   output logic                                    cfg_ack,
   // VMEbus levels and activity
   input  wire logic                               vme_write_n,
   input  wire logic                               vme_berr_n,
   input  wire logic                               bus_request_pending,
   input  wire logic                               bus_cycle_pending,
   // Error register link
   input  wire logic [vme_cfg_pkg::OTHER_ERR_W-1:0] other_errors,
   input  wire logic                               clr_arb_timeout,
   input  wire logic                               clr_xact_timeout,
   output logic                                    arb_timeout_flag,
   output logic                                    xact_timeout_flag,
   output logic                                    berr_status,
   // Control to the VME logic
   output logic                                    arb_enable,
   output vme_cfg_pkg::arb_mode_t                  arb_mode,
   output vme_cfg_pkg::page_size_t                 page_size,
   output logic      [1:0]                         request_level,
   output logic                                    vme_sm_reset
);

   import vme_cfg_pkg::*;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic       cfg_arb_en;
   arb_mode_t  cfg_arb_mode;
   page_size_t cfg_page;
   logic [1:0] cfg_req;
   logic [2:0] cfg_arb_to;
   logic [2:0] cfg_xact_to;
   logic       write_dir;
   logic       err_sum;
   logic       hit;
   logic       arb_expire;
   logic       xact_expire;
   logic       dir_locked;
   logic [TMR_W-1:0] arb_limit;
   logic [TMR_W-1:0] xact_limit;
   logic [31:0]      read_word;

   // Period decode for both timers, counts in clock cycles
   function automatic logic [TMR_W-1:0] period_cycles(input logic [2:0] code);
      logic [TMR_W-1:0] r;
      r = TMR_W'(CYC_800NS);
      case (code)
         3'h6:    r = TMR_W'(CYC_3MS28_P);
         3'h5:    r = TMR_W'(CYC_819US_P);
         3'h4:    r = TMR_W'(CYC_128US);
         3'h3:    r = TMR_W'(CYC_64US);
         3'h2:    r = TMR_W'(CYC_32US);
         3'h1:    r = TMR_W'(CYC_12US8);
         default: r = TMR_W'(CYC_800NS);
      endcase
      return r;
   endfunction

   assign hit        = (cfg_addr == DEV_CFG_OFFSET);
   assign arb_limit  = period_cycles(cfg_arb_to);
   assign xact_limit = period_cycles(cfg_xact_to);

   // ------------------------------------------------------------
   // Writable fields; full word writes only
   // ------------------------------------------------------------
   // enable, mode, size, level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_arb_en   <= ARB_EN_RST;
         cfg_arb_mode <= round_robin_mode;
         cfg_page     <= page_size_t'(PAGE_RST);
         cfg_req      <= REQ_RST;
      end else if (cfg_write && hit) begin
         cfg_arb_en   <= cfg_wdata[ARB_EN_BIT];
         cfg_arb_mode <= arb_mode_t'(cfg_wdata[ARB_MODE_LSB +: 2]);
         cfg_page     <= page_size_t'(cfg_wdata[PAGE_LSB +: 2]);
         cfg_req      <= cfg_wdata[REQ_LSB +: 2];
      end
   end

   // Timeout selects; reset leaves both disabled, so software must set them
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_arb_to  <= ARB_TO_RST;
         cfg_xact_to <= XACT_TO_RST;
      end else if (cfg_write && hit) begin
         cfg_arb_to  <= cfg_wdata[ARB_TO_LSB +: 3];
         cfg_xact_to <= cfg_wdata[XACT_TO_LSB +: 3];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         vme_sm_reset <= 1'b0;
      end else begin
         vme_sm_reset <= cfg_write && hit && cfg_wdata[SM_RESET_BIT];
      end
   end

   // ------------------------------------------------------------
   // Control outputs
   // ------------------------------------------------------------
   // enabled single level arbiter forces line three
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         arb_enable    <= ARB_EN_RST;
         arb_mode      <= round_robin_mode;
         page_size     <= page_size_t'(PAGE_RST);
         request_level <= REQ_RST;
      end else begin
         arb_enable    <= cfg_arb_en;
         arb_mode      <= cfg_arb_mode;
         page_size     <= cfg_page;
         request_level <= (cfg_arb_en && cfg_arb_mode == single_level_mode) ?
                          REQ_LINE_THREE : cfg_req;
      end
   end

   // ------------------------------------------------------------
   // Timers; the state machine reset rearms both
   // ------------------------------------------------------------
   // arbitration timer gated by enable
   timeout_timer u_arb_timer (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .restart  (vme_sm_reset),
      .active   (cfg_arb_en && bus_request_pending),
      .disabled (cfg_arb_to == TO_DISABLED),
      .limit    (arb_limit),
      .expire   (arb_expire)
   );

   timeout_timer u_xact_timer (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .restart  (vme_sm_reset),
      .active   (bus_cycle_pending),
      .disabled (cfg_xact_to == TO_DISABLED),
      .limit    (xact_limit),
      .expire   (xact_expire)
   );

   error_summary u_errors (
      .ref_clk           (ref_clk),
      .reset             (reset),
      .arb_expire        (arb_expire),
      .xact_expire       (xact_expire),
      .other_errors      (other_errors),
      .vme_berr_n        (vme_berr_n),
      .clr_arb_timeout   (clr_arb_timeout),
      .clr_xact_timeout  (clr_xact_timeout),
      .arb_timeout_flag  (arb_timeout_flag),
      .xact_timeout_flag (xact_timeout_flag),
      .berr_status       (berr_status),
      .error_summary_bit (err_sum)
   );

   // ------------------------------------------------------------
   // Write direction capture
   // ------------------------------------------------------------
   // Frozen while any timeout flag stands, so software sees the failing cycle
   assign dir_locked = arb_expire || xact_expire || arb_timeout_flag || xact_timeout_flag;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         write_dir <= 1'b0;
      end else if (!dir_locked) begin
         // low write line stored as one
         write_dir <= !vme_write_n;
      end
   end

   // ------------------------------------------------------------
   // Read path; unmapped offsets read zero
   // ------------------------------------------------------------
   always_comb begin
      read_word                        = 32'h0000_0000;
      read_word[ARB_EN_BIT]            = cfg_arb_en;
      read_word[ARB_MODE_LSB +: 2]     = cfg_arb_mode;
      read_word[ERR_SUM_BIT]           = err_sum;
      read_word[PAGE_LSB +: 2]         = cfg_page;
      read_word[REQ_LSB +: 2]          = cfg_req;
      read_word[WR_DIR_BIT]            = write_dir;
      read_word[ARB_TO_LSB +: 3]       = cfg_arb_to;
      read_word[XACT_TO_LSB +: 3]      = cfg_xact_to;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_ack   <= 1'b0;
      end else begin
         cfg_ack   <= cfg_read || cfg_write;
         cfg_rdata <= (cfg_read && hit) ? read_word : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_reset_values: assert property (disable iff (1'b0)
      $past(reset) && !reset |-> arb_enable && arb_mode == round_robin_mode
                       && page_size == page_4k && request_level == REQ_RST)
      else $error("control outputs wrong after reset");
   chk_mode_follows_write: assert property (
      (cfg_write && hit) ##1 1'b1 |=> arb_mode == arb_mode_t'($past(cfg_wdata[ARB_MODE_LSB +: 2], 2)))
      else $error("arbitration mode did not follow write");
   chk_page_follows_write: assert property (
      (cfg_write && hit) ##1 1'b1 |=> page_size == page_size_t'($past(cfg_wdata[PAGE_LSB +: 2], 2)))
      else $error("page size did not follow write");
   chk_single_level_line: assert property (
      $past(cfg_arb_en && cfg_arb_mode == single_level_mode) |-> request_level == REQ_LINE_THREE)
      else $error("single level arbiter not on line three");
   chk_dir_capture_inv: assert property (
      !$past(reset) && !$past(dir_locked) |-> write_dir == !$past(vme_write_n))
      else $error("write direction not captured inverted");
   chk_dir_frozen_lock: assert property (
      $past(dir_locked) |-> $stable(write_dir))
      else $error("write direction moved after timeout");
   chk_sm_reset_pulse: assert property (
      (cfg_write && hit && cfg_wdata[SM_RESET_BIT]) |=> vme_sm_reset ##1 !vme_sm_reset
                                                        || $past(cfg_write && hit, 1))
      else $error("state machine reset pulse wrong");
   chk_reset_bit_zero: assert property (
      cfg_ack |-> !cfg_rdata[SM_RESET_BIT])
      else $error("reset bit read as one");
   chk_arb_gated_enable: assert property (
      !cfg_arb_en [*2] |-> !arb_expire)
      else $error("arbitration timeout while arbiter disabled");
   chk_arb_decode_64us: assert property (
      cfg_arb_to == 3'h3 |-> arb_limit == TMR_W'(CYC_64US))
      else $error("arbitration 64 us code decoded wrong");
   chk_xact_decode_800ns: assert property (
      cfg_xact_to == 3'h0 |-> xact_limit == TMR_W'(CYC_800NS))
      else $error("transaction 800 ns code decoded wrong");
   chk_enable_readback: assert property (
      (cfg_read && hit) |=> cfg_ack && cfg_rdata[ARB_EN_BIT] == $past(cfg_arb_en))
      else $error("arbiter enable read back wrong");
   chk_level_follows_write: assert property (
      (cfg_write && hit) ##1 !(cfg_arb_en && cfg_arb_mode == single_level_mode)
      |=> request_level == $past(cfg_wdata[REQ_LSB +: 2], 2))
      else $error("request level did not follow write");
   chk_arb_flag_clear: assert property (
      (clr_arb_timeout && !arb_expire) |=> !arb_timeout_flag)
      else $error("arbitration timeout flag not cleared");
   chk_xact_flag_clear: assert property (
      (clr_xact_timeout && !xact_expire) |=> !xact_timeout_flag)
      else $error("transaction timeout flag not cleared");

   cov_xact_timeout: cover property (xact_expire ##1 xact_timeout_flag);
   cov_arb_timeout:  cover property (arb_expire ##1 arb_timeout_flag);
   cov_single_level: cover property (arb_enable && arb_mode == single_level_mode);
   cov_sm_reset:     cover property (vme_sm_reset);

endmodule // vme_adapter_config_control

`default_nettype wire

// *** test/vme_far_side.sv ***
// Behavioural VMEbus far side: write line, bus error, requesters, pending cycle
`timescale 1ns/100ps
`default_nettype none
module vme_far_side (
   // Clock
   input  wire logic       ref_clk,
   // Commands from the bench
   input  wire logic       do_write,
   input  wire logic       do_berr,
   input  wire logic       do_req,
   input  wire logic       do_cyc,
   input  wire logic [4:0] do_err,
   // Bus side levels
   output logic            vme_write_n,
   output logic            vme_berr_n,
   output logic            bus_request_pending,
   output logic            bus_cycle_pending,
   output logic [4:0]      other_errors
);
   // Idle bus: lines pulled high, nobody waiting
   initial begin
      vme_write_n = 1'h1;
      vme_berr_n = 1'h1;
      bus_request_pending = 1'h0;
      bus_cycle_pending = 1'h0;
      other_errors = 5'h0;
   end
   // Lines follow commands one edge late; no slave ever answers a pending cycle
   always @(posedge ref_clk) begin
      vme_write_n <= !do_write;
      vme_berr_n <= !do_berr;
      bus_request_pending <= do_req;
      bus_cycle_pending <= do_cyc;
      other_errors <= do_err;
   end
endmodule // vme_far_side
`default_nettype wire

// *** test/vme_adapter_config_control_bench.sv ***
// Self-checking bench for the device configuration register bank
`timescale 1ns/100ps
`default_nettype none
module vme_adapter_config_control_bench;
   import vme_cfg_pkg::*;
   localparam int P819 = 40;
   localparam int P3M  = 60;
   logic ref_clk = 1'h0, reset = 1'h1, cfg_write = 1'h0, cfg_read = 1'h0;
   logic [7:0] cfg_addr = 8'h0;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, d, lfsr = 32'h20DB;
   logic cfg_ack, vme_write_n, vme_berr_n, bus_request_pending, bus_cycle_pending;
   logic [4:0] other_errors, do_err = 5'h0;
   logic do_write = 1'h0, do_berr = 1'h0, do_req = 1'h0, do_cyc = 1'h0;
   logic clr_arb_timeout = 1'h0, clr_xact_timeout = 1'h0;
   logic arb_timeout_flag, xact_timeout_flag, berr_status, arb_enable, vme_sm_reset;
   arb_mode_t arb_mode;
   page_size_t page_size;
   logic [1:0] request_level;
   int fail_count = 0, n_checks = 0, m_en = 1, m_mode = 0, m_page = 0, m_req = 3;
   int m_ato = 7, m_xto = 7;
   always #25 ref_clk = ~ref_clk;
   vme_adapter_config_control #(.CYC_819US_P(P819), .CYC_3MS28_P(P3M))
      u_vme_adapter_config_control (.ref_clk, .reset, .cfg_addr, .cfg_write, .cfg_read,
      .cfg_wdata, .cfg_rdata, .cfg_ack, .vme_write_n, .vme_berr_n, .bus_request_pending,
      .bus_cycle_pending, .other_errors, .clr_arb_timeout, .clr_xact_timeout,
      .arb_timeout_flag, .xact_timeout_flag, .berr_status, .arb_enable, .arb_mode,
      .page_size, .request_level, .vme_sm_reset);
   vme_far_side u_vme_far_side (.ref_clk, .do_write, .do_berr, .do_req, .do_cyc, .do_err,
      .vme_write_n, .vme_berr_n, .bus_request_pending, .bus_cycle_pending, .other_errors);
   // -------------------------------------------------
   // Model, drivers and comparison
   // -------------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // Readback shows the written level field, never the forced one
   function automatic logic [31:0] word(input int err, input int wd);
      return 32'((m_en << 31) | (m_mode << 29) | (err << 28) | (m_page << 26)
         | (m_req << 24) | (wd << 23) | (m_ato << 19) | (m_xto << 16));
   endfunction
   task automatic final_report();
      $display("checks=%0d failures=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      cfg_addr <= a;
      cfg_write <= wr;
      cfg_read <= !wr;
      cfg_wdata <= wd;
      @(posedge ref_clk);
      cfg_write <= 1'h0;
      cfg_read <= 1'h0;
      #1;
      chk(32'(cfg_ack), 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      access(1'h0, a, 32'h0);
      chk(cfg_rdata, e);
   endtask
   task automatic wr(input logic [31:0] v);
      access(1'h1, 8'h40, v);
      chk(32'(vme_sm_reset), 32'(v[22]));
      {m_en, m_mode, m_page, m_req} = {31'h0, v[31], 30'h0, v[30:29], 30'h0, v[27:26], 30'h0, v[25:24]};
      m_ato = int'(v[21:19]);
      m_xto = int'(v[18:16]);
   endtask
   // Bounded wait for a timeout flag, counting edges from the request
   task automatic wait_flag(input logic arb, input int lo, input int hi);
      int k;
      k = 0;
      while ((arb ? arb_timeout_flag : xact_timeout_flag) !== 1'h1 && k < 500) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (k == 500) begin
         fail_count++;
         final_report();
      end else chk(32'(k >= lo && k <= hi), 32'h1);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'h0;
      rd(8'h40, 32'h833F0000);
      access(1'h1, 8'h44, 32'hFFFFFFFF);
      rd(8'h44, 32'h0);
      rd(8'h40, word(0, 0));
      // Sweep every mode with enable off and on, other fields random
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         d[31:29] = 3'(i);
         wr(d);
         @(posedge ref_clk);
         #1;
         chk(32'({arb_enable, arb_mode, page_size, request_level}),
            32'({m_en[0], m_mode[1:0], m_page[1:0],
            (m_en == 1 && m_mode == 3) ? 2'h3 : m_req[1:0]}));
         rd(8'h40, word(0, 0));
      end
      wr(32'h837F0000);
      rd(8'h40, word(0, 0));
      @(posedge ref_clk);
      do_write <= 1'h1;
      d = rnd();
      do_err <= d[4:0] | 5'h1;
      repeat (3) @(posedge ref_clk);
      rd(8'h40, word(1, 1));
      @(posedge ref_clk);
      do_err <= 5'h0;
      do_berr <= 1'h1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(32'(berr_status), 32'h1);
      rd(8'h40, word(1, 1));
      @(posedge ref_clk);
      do_berr <= 1'h0;
      wr(32'h83380000);
      @(posedge ref_clk);
      do_cyc <= 1'h1;
      wait_flag(1'h0, 17, 21);
      @(posedge ref_clk);
      do_write <= 1'h0;
      repeat (3) @(posedge ref_clk);
      rd(8'h40, word(1, 1));
      @(posedge ref_clk);
      do_cyc <= 1'h0;
      clr_xact_timeout <= 1'h1;
      @(posedge ref_clk);
      clr_xact_timeout <= 1'h0;
      repeat (3) @(posedge ref_clk);
      rd(8'h40, word(0, 0));
      wr(32'h832F0000);
      @(posedge ref_clk);
      do_req <= 1'h1;
      wait_flag(1'h1, P819 + 1, P819 + 5);
      @(posedge ref_clk);
      do_req <= 1'h0;
      clr_arb_timeout <= 1'h1;
      @(posedge ref_clk);
      clr_arb_timeout <= 1'h0;
      wr(32'h032F0000);
      @(posedge ref_clk);
      do_req <= 1'h1;
      repeat (2 * P819) @(posedge ref_clk);
      #1;
      chk(32'(arb_timeout_flag), 32'h0);
      wr(32'h833F0000);
      final_report();
   end
endmodule // vme_adapter_config_control_bench
`default_nettype wire
